// ===== hw/sus_pkg.sv
// Constants for the serial unit stop-control register bank
package sus_pkg;
  localparam logic [19:0] ADDR_MASK = 20'hFFFFF;
  // Register byte addresses
  localparam logic [19:0] OFF_PORT_DIR = 20'hFFF20;
  localparam logic [19:0] OFF_PORT_DATA = 20'hFFF00;
  localparam logic [19:0] OFF_PORT_MODE = 20'hF0050;
  localparam logic [19:0] OFF_NOISE_FILT = 20'hF0070;
  localparam logic [19:0] OFF_INPUT_SW = 20'hF0730;
  localparam logic [19:0] OFF_CLK_GATE = 20'hF00F0;
  localparam logic [19:0] OFF_STOP_TRIG = 20'hF0124;
  localparam logic [19:0] OFF_EN_STATUS = 20'hF0120;
  localparam logic [19:0] OFF_START_TRIG = 20'hF0128;
  localparam logic [19:0] OFF_OUT_EN = 20'hF012C;
  localparam logic [19:0] OFF_OUT_LEVEL = 20'hF0130;
  // Field layouts
  localparam int NUM_CH = 2;
  localparam int NUM_PINS = 5;
  localparam logic [7:0] PORT_DIR_FIXED = 8'hE0;
  localparam logic [7:0] PORT_DIR_RESET = 8'hFF;
  localparam logic [7:0] PORT_DATA_MASK = 8'h1F;
  localparam logic [7:0] PORT_MODE_MASK = 8'h01;
  localparam logic [7:0] NOISE_FILT_MASK = 8'h01;
  localparam logic [7:0] INPUT_SW_MASK = 8'h03;
  localparam int CLK_GATE_BIT = 2;
  localparam logic [1:0] CH_MASK = 2'h3;
  localparam logic [1:0] OUT_EN_MASK = 2'h1;
  // Output level register: data levels in [1:0], clock levels in [9:8]
  localparam int DATA_LVL_LSB = 0;
  localparam int CLK_LVL_LSB = 8;
  localparam logic [1:0] LEVEL_RESET = 2'h3;
  localparam logic [1:0] CH_EN_RESET = 2'h0;
  localparam logic [0:0] OUT_EN_RESET = 1'h0;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ===== hw/sus_pin_mux.sv
// Per-pin output mux between serial engine and port logic
`timescale 1ns/1ps
`default_nettype none
module sus_pin_mux (
  // Port side
  input wire logic pin_direction_bit,
  input wire logic port_value,
  // Serial side
  input wire logic serial_owns,
  input wire logic serial_value,
  // Pin
  output logic pin_out,
  output logic pin_oe
);
  assign pin_oe = !pin_direction_bit;
  // Port data ANDs with the serial level, so port data 1 passes serial
  assign pin_out = serial_owns ? (serial_value & port_value) : port_value;
endmodule
`default_nettype wire

// ===== hw/sus_top.sv
// Serial unit stop-control register bank with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module sus_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial engine side
  input wire logic [1:0] serial_clk_out,
  input wire logic [1:0] serial_data_out,
  input wire logic [1:0] start_req,
  output logic unit_clk_en,
  output logic [1:0] channel_run,
  // Port pins
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe,
  output logic [1:0] clk_pin_level,
  output logic [1:0] data_pin_level
);
  typedef struct packed {
    logic [7:0] port_dir;
    logic [7:0] port_data;
    logic [7:0] port_mode;
    logic [7:0] noise_filt;
    logic [7:0] input_sw;
    logic clk_gate;
    logic [1:0] ch_en;
    logic [0:0] out_en;
    logic [1:0] clk_lvl;
    logic [1:0] data_lvl;
    logic [1:0] clk_pin;
    logic [1:0] data_pin;
    logic wr_pend;
    logic [19:0] wr_addr;
    logic [31:0] rdata;
  } sus_state_s;

  sus_state_s st_q;
  sus_state_s st_d;

  function automatic logic hit(input logic [19:0] a, input logic [19:0] off);
    hit = (a == off);
  endfunction

  function automatic logic in_unit(input logic [19:0] a);
    in_unit = hit(a, sus_pkg::OFF_STOP_TRIG) || hit(a, sus_pkg::OFF_EN_STATUS)
      || hit(a, sus_pkg::OFF_START_TRIG) || hit(a, sus_pkg::OFF_OUT_EN)
      || hit(a, sus_pkg::OFF_OUT_LEVEL);
  endfunction

  logic addr_phase;
  logic [19:0] a_addr;
  logic [19:0] w_addr;
  logic unit_open;

  assign addr_phase = hsel && hready && (htrans == sus_pkg::HTRANS_NONSEQ);
  assign a_addr = haddr[19:0];
  assign w_addr = st_q.wr_addr;
  assign unit_open = st_q.clk_gate;

  always_comb
  begin
    st_d = st_q;
    st_d.wr_pend = 1'b0;
    // Engine may start a channel only while the unit is clocked
    st_d.ch_en = st_q.ch_en | (start_req & {2{unit_open}});
    if (st_q.wr_pend)
    begin
      if (hit(w_addr, sus_pkg::OFF_PORT_DIR))
        st_d.port_dir = hwdata[7:0] | sus_pkg::PORT_DIR_FIXED;
      if (hit(w_addr, sus_pkg::OFF_PORT_DATA))
        st_d.port_data = hwdata[7:0] & sus_pkg::PORT_DATA_MASK;
      if (hit(w_addr, sus_pkg::OFF_PORT_MODE))
        st_d.port_mode = hwdata[7:0] & sus_pkg::PORT_MODE_MASK;
      if (hit(w_addr, sus_pkg::OFF_NOISE_FILT))
        st_d.noise_filt = hwdata[7:0] & sus_pkg::NOISE_FILT_MASK;
      if (hit(w_addr, sus_pkg::OFF_INPUT_SW))
        st_d.input_sw = hwdata[7:0] & sus_pkg::INPUT_SW_MASK;
      if (hit(w_addr, sus_pkg::OFF_CLK_GATE))
        st_d.clk_gate = hwdata[sus_pkg::CLK_GATE_BIT];
      if (unit_open && in_unit(w_addr))
      begin
        if (hit(w_addr, sus_pkg::OFF_STOP_TRIG))
          st_d.ch_en = st_d.ch_en & ~(hwdata[1:0] & sus_pkg::CH_MASK);
        if (hit(w_addr, sus_pkg::OFF_START_TRIG))
          st_d.ch_en = st_d.ch_en | (hwdata[1:0] & sus_pkg::CH_MASK);
        if (hit(w_addr, sus_pkg::OFF_OUT_EN))
          st_d.out_en = hwdata[0:0] & sus_pkg::OUT_EN_MASK[0:0];
        if (hit(w_addr, sus_pkg::OFF_OUT_LEVEL))
        begin
          st_d.data_lvl = hwdata[sus_pkg::DATA_LVL_LSB +: 2];
          st_d.clk_lvl = hwdata[sus_pkg::CLK_LVL_LSB +: 2];
        end
      end
    end
    // Gating the unit off returns its registers to defaults
    if (!st_d.clk_gate)
    begin
      st_d.ch_en = sus_pkg::CH_EN_RESET;
      st_d.out_en = sus_pkg::OUT_EN_RESET;
      st_d.clk_lvl = sus_pkg::LEVEL_RESET;
      st_d.data_lvl = sus_pkg::LEVEL_RESET;
    end
    // Pin levels: clocks from serial engine while running; ch0 data only when running and output enabled, ch1 data always level
    for (int i = 0; i < sus_pkg::NUM_CH; i++)
    begin
      st_d.clk_pin[i] = st_q.ch_en[i] ? serial_clk_out[i] : st_q.clk_lvl[i];
      if (i == 0 && st_q.out_en[0] && st_q.ch_en[0])
        st_d.data_pin[i] = serial_data_out[i];
      else
        st_d.data_pin[i] = st_q.data_lvl[i];
    end
    if (addr_phase && hwrite)
    begin
      st_d.wr_pend = 1'b1;
      st_d.wr_addr = a_addr;
    end
    if (addr_phase && !hwrite)
    begin
      st_d.rdata = 32'h0000_0000;
      // Fixed-one bits read back through the stored value
      if (hit(a_addr, sus_pkg::OFF_PORT_DIR))
        st_d.rdata[7:0] = st_d.port_dir;
      if (hit(a_addr, sus_pkg::OFF_PORT_DATA))
        st_d.rdata[7:0] = st_d.port_data;
      if (hit(a_addr, sus_pkg::OFF_PORT_MODE))
        st_d.rdata[7:0] = st_d.port_mode;
      if (hit(a_addr, sus_pkg::OFF_NOISE_FILT))
        st_d.rdata[7:0] = st_d.noise_filt;
      if (hit(a_addr, sus_pkg::OFF_INPUT_SW))
        st_d.rdata[7:0] = st_d.input_sw;
      if (hit(a_addr, sus_pkg::OFF_CLK_GATE))
        st_d.rdata[sus_pkg::CLK_GATE_BIT] = st_d.clk_gate;
      // Stop and start triggers always read zero
      if (hit(a_addr, sus_pkg::OFF_EN_STATUS))
        st_d.rdata[1:0] = st_d.ch_en;
      if (hit(a_addr, sus_pkg::OFF_OUT_EN))
        st_d.rdata[0:0] = st_d.out_en;
      if (hit(a_addr, sus_pkg::OFF_OUT_LEVEL))
      begin
        st_d.rdata[sus_pkg::DATA_LVL_LSB +: 2] = st_d.data_lvl;
        st_d.rdata[sus_pkg::CLK_LVL_LSB +: 2] = st_d.clk_lvl;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
      st_q.port_dir <= sus_pkg::PORT_DIR_RESET;
      st_q.clk_lvl <= sus_pkg::LEVEL_RESET;
      st_q.data_lvl <= sus_pkg::LEVEL_RESET;
      st_q.clk_pin <= sus_pkg::LEVEL_RESET;
      st_q.data_pin <= sus_pkg::LEVEL_RESET;
    end
    else
      st_q <= st_d;
  end

  assign hrdata = st_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign unit_clk_en = st_q.clk_gate;
  assign channel_run = st_q.ch_en;
  assign clk_pin_level = st_q.clk_pin;
  assign data_pin_level = st_q.data_pin;

  // Pin 0 carries channel 0 data, 2..3 channel clocks, 1 and 4 plain port
  logic [4:0] serial_owns;
  logic [4:0] serial_val;
  // Channel 0 data sits on pin 0, beside its level in serial_val bit 0
  assign serial_owns = {1'b0, st_q.ch_en, 1'b0,
    st_q.ch_en[0] & st_q.out_en[0]};
  assign serial_val = {1'b0, st_q.clk_pin, st_q.data_pin};

  genvar g;
  generate
    for (g = 0; g < sus_pkg::NUM_PINS; g++)
    begin : g_pin
      sus_pin_mux u_mux (
        .pin_direction_bit(st_q.port_dir[g]),
        .port_value(st_q.port_data[g]),
        .serial_owns(serial_owns[g]),
        .serial_value(serial_val[g]),
        .pin_out(pin_out[g]),
        .pin_oe(pin_oe[g])
      );
    end
  endgenerate

  // Assertions
  sequence s_stop_write;
    st_q.wr_pend && hit(st_q.wr_addr, sus_pkg::OFF_STOP_TRIG)
      && st_q.clk_gate && hwdata[0];
  endsequence

  a_dir_fixed_ones: assert property (@(posedge clk) disable iff (!reset_n)
    st_q.port_dir[7:5] == 3'h7) else $error("fixed dir bits lost");
  a_pin_oe_dir: assert property (@(posedge clk) disable iff (!reset_n)
    pin_oe == ~st_q.port_dir[4:0]) else $error("oe not from dir");
  a_stop_clears: assert property (@(posedge clk) disable iff (!reset_n)
    s_stop_write |=> !channel_run[0]) else $error("stop ignored");
  a_gate_stops: assert property (@(posedge clk) disable iff (!reset_n)
    !unit_clk_en |-> channel_run == 2'h0) else $error("run while off");
  a_gate_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.wr_pend && !st_q.clk_gate && hit(st_q.wr_addr, sus_pkg::OFF_OUT_EN))
    |=> st_q.out_en == 1'b0) else $error("write while gated");
  a_status_read: assert property (@(posedge clk) disable iff (!reset_n)
    (addr_phase && !hwrite && hit(a_addr, sus_pkg::OFF_EN_STATUS))
    |=> hrdata[31:2] == 30'h0 && hrdata[1:0] == st_q.ch_en)
    else $error("status read");
  a_trig_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (addr_phase && !hwrite && hit(a_addr, sus_pkg::OFF_STOP_TRIG))
    |=> hrdata == 32'h0) else $error("trigger reads nonzero");
  a_data_level: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(st_q.out_en[0]) |-> data_pin_level[0] == $past(st_q.data_lvl[0]))
    else $error("data level not driven");
  a_clk_level: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(st_q.ch_en[1]) |-> clk_pin_level[1] == $past(st_q.clk_lvl[1]))
    else $error("clock level not driven");
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the serial unit stop-control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [19:0] RW_ADDR [4] = '{sus_pkg::OFF_PORT_DATA,
    sus_pkg::OFF_PORT_MODE, sus_pkg::OFF_NOISE_FILT, sus_pkg::OFF_INPUT_SW};
  localparam logic [7:0] RW_MASK [4] = '{sus_pkg::PORT_DATA_MASK,
    sus_pkg::PORT_MODE_MASK, sus_pkg::NOISE_FILT_MASK, sus_pkg::INPUT_SW_MASK};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] sclk = 2'h3;
  logic [1:0] sdat = 2'h3;
  logic [1:0] start_req = 2'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic unit_clk_en;
  logic [1:0] channel_run;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  logic [1:0] clk_pin_level;
  logic [1:0] data_pin_level;
  int failures = 0;
  int cmp_count = 0;
  int seed = 77;
  logic [31:0] exp_q [$];
  string name_q [$];
  logic [31:0] seen_v;
  event obs_ev;

  sus_top dut (.clk(clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(sus_pkg::HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_clk_out(sclk),
    .serial_data_out(sdat), .start_req(start_req), .unit_clk_en(unit_clk_en),
    .channel_run(channel_run), .pin_out(pin_out), .pin_oe(pin_oe),
    .clk_pin_level(clk_pin_level), .data_pin_level(data_pin_level));

  initial forever #25 clk = ~clk;

  // Engine levels wander so a stuck mux shows up
  always @(posedge clk)
  begin
    sclk <= 2'($random(seed));
    sdat <= 2'($random(seed));
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      failures++;
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        failures++;
        print_verdict();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus(logic w, logic [19:0] a, logic [31:0] wd,
    output logic [31:0] rd);
    htrans <= sus_pkg::HTRANS_NONSEQ;
    haddr <= {12'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic obs(string nm, logic [31:0] exp, logic [31:0] seen);
    name_q.push_back(nm);
    exp_q.push_back(exp);
    seen_v = seen;
    ->obs_ev;
    #1;
  endtask

  task automatic wr(logic [19:0] a, logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(string nm, logic [19:0] a, logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    obs(nm, exp, x);
  endtask

  initial forever
  begin
    @(obs_ev);
    check(name_q.pop_front(), seen_v, exp_q.pop_front());
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial
  begin
    logic [31:0] r;
    logic [1:0] k;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd("dir_reset", sus_pkg::OFF_PORT_DIR, 32'hFF);
    rd("lvl_gated", sus_pkg::OFF_OUT_LEVEL, 32'h303);
    for (int i = 0; i < 4; i++)
    begin
      // Undefined bits written as zero
      r = $random(seed) & {24'h0, RW_MASK[i]};
      wr(RW_ADDR[i], r);
      rd("always_rw", RW_ADDR[i], r);
    end
    r = $random(seed) & 32'h1F;
    wr(sus_pkg::OFF_PORT_DIR, r);
    rd("dir", sus_pkg::OFF_PORT_DIR, r | 32'hE0);
    obs("pin_oe", {27'h0, ~r[4:0]}, {27'h0, pin_oe});
    wr(sus_pkg::OFF_OUT_EN, 32'h1);
    rd("oe_gated", sus_pkg::OFF_OUT_EN, 32'h0);
    wr(sus_pkg::OFF_CLK_GATE, 32'h4);
    start_req <= 2'h3;
    @(posedge clk);
    start_req <= 2'h0;
    // Gate bit has settled one edge after the write landed
    obs("unit_clk_en", 32'h1, {31'h0, unit_clk_en});
    repeat (2) @(posedge clk);
    obs("run_start", 32'h3, {30'h0, channel_run});
    wr(sus_pkg::OFF_EN_STATUS, 32'h0);
    rd("status_ro", sus_pkg::OFF_EN_STATUS, 32'h3);
    for (int c = 0; c < 2; c++)
    begin
      wr(sus_pkg::OFF_STOP_TRIG, 32'h1 << c);
      @(posedge clk);
      obs("run_stop", c == 0 ? 32'h2 : 32'h0, {30'h0, channel_run});
      rd("stop_clear", sus_pkg::OFF_STOP_TRIG, 32'h0);
    end
    rd("status_stop", sus_pkg::OFF_EN_STATUS, 32'h0);
    wr(sus_pkg::OFF_OUT_EN, 32'h1);
    rd("oe_on", sus_pkg::OFF_OUT_EN, 32'h1);
    wr(sus_pkg::OFF_OUT_EN, 32'h0);
    rd("oe_off", sus_pkg::OFF_OUT_EN, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      k = 2'(i);
      wr(sus_pkg::OFF_OUT_LEVEL, {22'h0, k, 6'h0, ~k});
      repeat (2) @(posedge clk);
      obs("clk_lvl", {30'h0, k}, {30'h0, clk_pin_level});
      obs("data_lvl", {30'h0, ~k}, {30'h0, data_pin_level});
      rd("lvl", sus_pkg::OFF_OUT_LEVEL, {22'h0, k, 6'h0, ~k});
    end
    rd("unmapped", 20'hF0200, 32'h0);
    wr(sus_pkg::OFF_CLK_GATE, 32'h0);
    wr(sus_pkg::OFF_OUT_LEVEL, 32'h0);
    rd("lvl_default", sus_pkg::OFF_OUT_LEVEL, 32'h303);
    // Stopped unit: shared pins follow port data only
    wr(sus_pkg::OFF_PORT_DATA, 32'h0A);
    @(posedge clk);
    obs("pin_out", 32'h0A, {27'h0, pin_out});
    print_verdict();
  end
endmodule
`default_nettype wire
